//--- hspc_pkg.sv
// Constants for the high speed pulse counter
`default_nettype none
package hspc_pkg;
    // Register byte offsets
    localparam logic [7:0]  HSPC_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  HSPC_CMD_OFS      = 8'h04;
    localparam logic [7:0]  HSPC_SETLO_OFS    = 8'h08;
    localparam logic [7:0]  HSPC_SETHI_OFS    = 8'h0C;
    localparam logic [7:0]  HSPC_COUNT_OFS    = 8'h10;
    localparam logic [7:0]  HSPC_STATUS_OFS   = 8'h14;
    localparam logic [7:0]  HSPC_IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0]  HSPC_IRQ_MASK_OFS = 8'h1C;
    // Control fields
    localparam int          HSPC_CTRL_ENABLE  = 0;
    localparam int          HSPC_CTRL_DIRSEL  = 1;
    localparam int          HSPC_CTRL_TYPE_LO = 2;
    localparam int          HSPC_CTRL_FOUR    = 4;
    localparam int          HSPC_CTRL_USE_ST  = 5;
    localparam int          HSPC_CTRL_USE_RST = 6;
    localparam int          HSPC_CTRL_LATCHED = 7;
    localparam int          HSPC_CTRL_W       = 8;
    localparam logic [7:0]  HSPC_CTRL_RESET   = 8'h00;
    // Command fields
    localparam int          HSPC_CMD_RESET    = 0;
    // Status fields
    localparam int          HSPC_ST_CONTACT   = 0;
    localparam int          HSPC_ST_DIRMON    = 1;
    localparam int          HSPC_ST_RUNNING   = 2;
    // Interrupt event fields
    localparam int          HSPC_EV_ON        = 0;
    localparam int          HSPC_EV_OFF       = 1;
    localparam int          HSPC_EV_WRAP      = 2;
    localparam int          HSPC_EV_XRST      = 3;
    localparam int          HSPC_EV_W         = 4;
    localparam logic [3:0]  HSPC_EV_RESET     = 4'h0;
    // Value limits and reset values
    localparam logic [31:0] HSPC_MAX_POS      = 32'h7FFFFFFF;
    localparam logic [31:0] HSPC_MIN_NEG      = 32'h80000000;
    localparam logic [31:0] HSPC_ZERO         = 32'h00000000;
    localparam logic [15:0] HSPC_WORD_RESET   = 16'h0000;
    // Counter types
    localparam logic [1:0]  HSPC_TYPE_SINGLE  = 2'h0;
    localparam logic [1:0]  HSPC_TYPE_DUAL    = 2'h1;
    localparam logic [1:0]  HSPC_TYPE_QUAD    = 2'h2;
    // Run states, one-hot
    typedef enum logic [2:0] {
        HSPC_IDLE = 3'b001,
        HSPC_WAIT = 3'b010,
        HSPC_RUN  = 3'b100
    } hspc_state_e;
endpackage : hspc_pkg
`default_nettype wire

//--- hspc_top.sv
// High speed pulse counter with register port and interrupt
//
// Our own choices: the register addresses and the address-and-strobe port.
`default_nettype none
module hspc_top
    import hspc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output var  logic [31:0] RDATA,
    // Count terminals
    input  wire logic        COUNT_INPUT_TERMINAL_0,
    input  wire logic        COUNT_INPUT_TERMINAL_1,
    input  wire logic        EXTERNAL_RESET_TERMINAL,
    input  wire logic        EXTERNAL_START_TERMINAL,
    // Power restore pulse
    input  wire logic        POWER_RESTORE,
    // Counter outputs
    output var  logic [31:0] COUNT_VALUE,
    output var  logic        OUTPUT_CONTACT,
    output var  logic        DIRECTION_MONITOR_FLAG,
    output var  logic        IRQ
);

    // Next value after one step
    function automatic logic [31:0] step_value(input logic [31:0] v, input logic down);
        step_value = down ? v - 32'h00000001 : v + 32'h00000001;
    endfunction : step_value

    // Write strobe for one register
    function automatic logic wr_hit(input logic wr_s, input logic [7:0] a,
                                    input logic [7:0] ofs);
        wr_hit = wr_s && (a == ofs);
    endfunction : wr_hit

    // Registers
    logic [HSPC_CTRL_W-1:0] ctrl_q;
    logic [15:0]            set_lo_q;
    logic [15:0]            set_hi_q;
    logic [HSPC_EV_W-1:0]   irq_stat_q;
    logic [HSPC_EV_W-1:0]   irq_mask_q;
    logic [31:0]            count_q;
    logic [31:0]            count_d;
    logic                   contact_q;
    logic                   contact_d;
    logic                   dirmon_q;
    logic                   dirmon_d;
    logic                   in0_q;
    logic                   in1_q;
    logic                   start_q;
    logic                   reset_hold_q;
    hspc_state_e            state_q;
    hspc_state_e            state_d;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;
    logic                   irq_q;

    // Control fields
    wire logic              enable_cond  = ctrl_q[HSPC_CTRL_ENABLE];
    wire logic              dir_select   = ctrl_q[HSPC_CTRL_DIRSEL];
    wire logic [1:0]        ctr_type     = ctrl_q[HSPC_CTRL_TYPE_LO +: 2];
    wire logic              four_edge    = ctrl_q[HSPC_CTRL_FOUR];
    wire logic              use_start    = ctrl_q[HSPC_CTRL_USE_ST];
    wire logic              use_ext_rst  = ctrl_q[HSPC_CTRL_USE_RST];
    wire logic              latched_type = ctrl_q[HSPC_CTRL_LATCHED];

    // Register port decode
    wire logic              wr_ctrl  = wr_hit(WR, ADDR, HSPC_CTRL_OFS);
    wire logic              wr_cmd   = wr_hit(WR, ADDR, HSPC_CMD_OFS);
    wire logic              wr_setlo = wr_hit(WR, ADDR, HSPC_SETLO_OFS);
    wire logic              wr_sethi = wr_hit(WR, ADDR, HSPC_SETHI_OFS);
    wire logic              wr_istat = wr_hit(WR, ADDR, HSPC_IRQ_STAT_OFS);
    wire logic              wr_imask = wr_hit(WR, ADDR, HSPC_IRQ_MASK_OFS);

    // Set value from two data words
    wire logic [31:0]       set_value = {set_hi_q, set_lo_q};

    // Input edges
    wire logic              in0_rise = COUNT_INPUT_TERMINAL_0 && !in0_q;
    wire logic              in0_fall = !COUNT_INPUT_TERMINAL_0 && in0_q;
    wire logic              in1_rise = COUNT_INPUT_TERMINAL_1 && !in1_q;
    wire logic              in1_fall = !COUNT_INPUT_TERMINAL_1 && in1_q;
    wire logic              start_rise = EXTERNAL_START_TERMINAL && !start_q;

    // Reset sources
    wire logic              prog_reset = wr_cmd && WDATA[HSPC_CMD_RESET];
    wire logic              ext_reset  = use_ext_rst && EXTERNAL_RESET_TERMINAL;
    wire logic              any_reset  = prog_reset || ext_reset;
    wire logic              power_clear = POWER_RESTORE && !latched_type;

    // Counting allowed only while running
    wire logic              running = (state_q == HSPC_RUN);

    // Single input: edge on terminal 0, direction from flag
    wire logic              single_step = in0_rise;
    wire logic              single_down = dir_select;

    // Dual input: up on terminal 0, down on terminal 1
    wire logic              dual_step = in0_rise ^ in1_rise;
    wire logic              dual_down = in1_rise;

    // Quadrature four-edge: an edge on one phase only (not both in one cycle), direction from phase order
    wire logic              a_edge = in0_rise || in0_fall;
    wire logic              b_edge = in1_rise || in1_fall;
    wire logic              quad4_step = a_edge ^ b_edge;
    wire logic              quad4_down = a_edge ? (COUNT_INPUT_TERMINAL_0 == in1_q)
                                                : (COUNT_INPUT_TERMINAL_1 != in0_q);

    // Quadrature one-edge: A edges while B low, once per cycle
    wire logic              quad1_step = (in0_rise || in0_fall)
                                         && !COUNT_INPUT_TERMINAL_1 && !in1_q;
    wire logic              quad1_down = in0_fall;

    wire logic              quad_step = four_edge ? quad4_step : quad1_step;
    wire logic              quad_down = four_edge ? quad4_down : quad1_down;

    // Type selection
    wire logic              type_step = (ctr_type == HSPC_TYPE_SINGLE) ? single_step :
                                        (ctr_type == HSPC_TYPE_DUAL)   ? dual_step   :
                                        (ctr_type == HSPC_TYPE_QUAD)   ? quad_step   :
                                        1'b0;
    wire logic              type_down = (ctr_type == HSPC_TYPE_SINGLE) ? single_down :
                                        (ctr_type == HSPC_TYPE_DUAL)   ? dual_down   :
                                        quad_down;

    wire logic              do_step  = running && type_step;
    wire logic [31:0]       stepped  = step_value(count_q, type_down);

    // Contact transitions, same for every type
    wire logic              hit_on  = do_step && !type_down
                                      && (stepped == set_value);
    wire logic              hit_off = do_step && type_down
                                      && (count_q == set_value);
    wire logic              wrapped = do_step && (type_down ? (count_q == HSPC_MIN_NEG)
                                                            : (count_q == HSPC_MAX_POS));

    // Events
    wire logic [HSPC_EV_W-1:0] events = {ext_reset && !reset_hold_q, wrapped,
                                         hit_off && contact_q, hit_on && !contact_q};
    wire logic [HSPC_EV_W-1:0] istat_d = (irq_stat_q & ~(wr_istat ? WDATA[HSPC_EV_W-1:0]
                                                                  : HSPC_EV_RESET)) | events;

    // Run state
    always_comb begin
        state_d = state_q;
        case (state_q)
            HSPC_IDLE: begin
                if (enable_cond) begin
                    state_d = use_start ? HSPC_WAIT : HSPC_RUN;
                end
            end
            HSPC_WAIT: begin
                if (!enable_cond) begin
                    state_d = HSPC_IDLE;
                end else if (start_rise) begin
                    state_d = HSPC_RUN;
                end
            end
            HSPC_RUN: begin
                if (!enable_cond) begin
                    state_d = HSPC_IDLE;
                end else if (any_reset && use_start) begin
                    state_d = HSPC_WAIT;
                end
            end
            default: begin
                state_d = HSPC_IDLE;
            end
        endcase
    end

    // Count, contact and direction next values
    always_comb begin
        count_d   = count_q;
        contact_d = contact_q;
        dirmon_d  = dirmon_q;
        if (any_reset || power_clear) begin
            count_d   = HSPC_ZERO;
            contact_d = 1'b0;
        end else if (do_step) begin
            count_d = stepped;
            if (hit_on) begin
                contact_d = 1'b1;
            end else if (hit_off) begin
                contact_d = 1'b0;
            end
        end
        if (do_step && ctr_type != HSPC_TYPE_SINGLE) begin
            dirmon_d = type_down;
        end else if (ctr_type == HSPC_TYPE_SINGLE) begin
            dirmon_d = dir_select;
        end
    end

    // Read mux
    always_comb begin
        rdata_d = HSPC_ZERO;
        case (ADDR)
            HSPC_CTRL_OFS:     rdata_d[HSPC_CTRL_W-1:0] = ctrl_q;
            HSPC_SETLO_OFS:    rdata_d[15:0] = set_lo_q;
            HSPC_SETHI_OFS:    rdata_d[15:0] = set_hi_q;
            HSPC_COUNT_OFS:    rdata_d = count_q;
            HSPC_STATUS_OFS: begin
                rdata_d[HSPC_ST_CONTACT] = contact_q;
                rdata_d[HSPC_ST_DIRMON]  = dirmon_q;
                rdata_d[HSPC_ST_RUNNING] = running;
            end
            HSPC_IRQ_STAT_OFS: rdata_d[HSPC_EV_W-1:0] = irq_stat_q;
            HSPC_IRQ_MASK_OFS: rdata_d[HSPC_EV_W-1:0] = irq_mask_q;
            default:           rdata_d = HSPC_ZERO;
        endcase
        if (!RD) begin
            rdata_d = HSPC_ZERO;
        end
    end

    // Control register
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= HSPC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= WDATA[HSPC_CTRL_W-1:0];
        end
    end

    // Set value low word
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            set_lo_q <= HSPC_WORD_RESET;
        end else if (wr_setlo) begin
            set_lo_q <= WDATA[15:0];
        end
    end

    // Set value high word
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            set_hi_q <= HSPC_WORD_RESET;
        end else if (wr_sethi) begin
            set_hi_q <= WDATA[15:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_mask_q <= HSPC_EV_RESET;
        end else if (wr_imask) begin
            irq_mask_q <= WDATA[HSPC_EV_W-1:0];
        end
    end

    // Terminal 0 history
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            in0_q <= 1'b0;
        end else begin
            in0_q <= COUNT_INPUT_TERMINAL_0;
        end
    end

    // Terminal 1 history
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            in1_q <= 1'b0;
        end else begin
            in1_q <= COUNT_INPUT_TERMINAL_1;
        end
    end

    // Start terminal history
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            start_q <= 1'b0;
        end else begin
            start_q <= EXTERNAL_START_TERMINAL;
        end
    end

    // External reset history
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            reset_hold_q <= 1'b0;
        end else begin
            reset_hold_q <= ext_reset;
        end
    end

    // Current count
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            count_q <= HSPC_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // Output contact
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            contact_q <= 1'b0;
        end else begin
            contact_q <= contact_d;
        end
    end

    // Direction monitor
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dirmon_q <= 1'b0;
        end else begin
            dirmon_q <= dirmon_d;
        end
    end

    // Run state
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= HSPC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Interrupt status, set wins over clear
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_stat_q <= HSPC_EV_RESET;
        end else begin
            irq_stat_q <= istat_d;
        end
    end

    // Interrupt line
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(istat_d & irq_mask_q);
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= HSPC_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign RDATA                  = rdata_q;
    assign COUNT_VALUE            = count_q;
    assign OUTPUT_CONTACT         = contact_q;
    assign DIRECTION_MONITOR_FLAG = dirmon_q;
    assign IRQ                    = irq_q;

endmodule : hspc_top
`default_nettype wire

//--- hspc_assertions.sv
// Port checker for the high speed pulse counter
`default_nettype none
module hspc_checker
    import hspc_pkg::*;
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST_B,
    // Register port
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    // Terminals and outputs
    input wire logic        COUNT_INPUT_TERMINAL_0,
    input wire logic        COUNT_INPUT_TERMINAL_1,
    input wire logic [31:0] COUNT_VALUE,
    input wire logic        OUTPUT_CONTACT,
    input wire logic        DIRECTION_MONITOR_FLAG,
    input wire logic        IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data not zero outside a read");
    read_count_a: assert property (RD && ADDR == HSPC_COUNT_OFS |=>
        RDATA == $past(COUNT_VALUE)) else $error("count read mismatch");
    read_status_a: assert property (RD && ADDR == HSPC_STATUS_OFS |=>
        RDATA[1:0] == {$past(DIRECTION_MONITOR_FLAG), $past(OUTPUT_CONTACT)}
        && RDATA[31:3] == 29'h0) else $error("status read mismatch");
    step_size_a: assert property ($changed(COUNT_VALUE) |->
        COUNT_VALUE == $past(COUNT_VALUE) + 32'h1 || COUNT_VALUE == HSPC_ZERO
        || COUNT_VALUE == $past(COUNT_VALUE) - 32'h1) else $error("count jump");
    step_cause_a: assert property ($changed(COUNT_VALUE) && COUNT_VALUE != HSPC_ZERO |->
        $past(COUNT_INPUT_TERMINAL_0) != $past(COUNT_INPUT_TERMINAL_0, 2)
        || $past(COUNT_INPUT_TERMINAL_1) != $past(COUNT_INPUT_TERMINAL_1, 2))
        else $error("count step without input edge");
    contact_on_a: assert property ($rose(OUTPUT_CONTACT) |->
        COUNT_VALUE == $past(COUNT_VALUE) + 32'h1) else $error("contact on without up step");
    contact_off_a: assert property ($fell(OUTPUT_CONTACT) |->
        COUNT_VALUE == $past(COUNT_VALUE) - 32'h1 || COUNT_VALUE == HSPC_ZERO)
        else $error("contact off without down step");
    cmd_reset_a: assert property (WR && ADDR == HSPC_CMD_OFS && WDATA[HSPC_CMD_RESET]
        |-> ##[1:2] (COUNT_VALUE == HSPC_ZERO && !OUTPUT_CONTACT))
        else $error("program reset did not clear");

    cover property ($rose(OUTPUT_CONTACT));
    cover property ($rose(IRQ));
    cover property ($rose(DIRECTION_MONITOR_FLAG));
endmodule : hspc_checker

bind hspc_top hspc_checker chk_i (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .COUNT_INPUT_TERMINAL_0(COUNT_INPUT_TERMINAL_0),
    .COUNT_INPUT_TERMINAL_1(COUNT_INPUT_TERMINAL_1), .COUNT_VALUE(COUNT_VALUE),
    .OUTPUT_CONTACT(OUTPUT_CONTACT), .DIRECTION_MONITOR_FLAG(DIRECTION_MONITOR_FLAG),
    .IRQ(IRQ));
`default_nettype wire

//--- hspc_source.sv
// Pulse source and quadrature encoder model
`default_nettype none
module hspc_source (
    // Clock
    input  wire logic clk,
    // Lines to the counting terminals
    output var  logic phase_a,
    output var  logic phase_b
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
    end

    // Lines change after an edge and stay stable gap cycles
    task automatic hold(input logic a, input logic b, input int gap);
        phase_a <= a;
        phase_b <= b;
        repeat (gap) @(posedge clk);
    endtask : hold

    // Whole pulses on one line, the other line held
    task automatic pulse(input bit on_b, input int n, input int gap);
        for (int i = 0; i < 2 * n; i++) begin
            hold(on_b ? phase_a : ~phase_a, on_b ? ~phase_b : phase_b, gap);
        end
    endtask : pulse

    // Full quadrature cycles, phases a quarter cycle apart
    task automatic quad(input int n, input bit down, input int gap);
        logic [1:0] seq [4];
        logic [1:0] s;
        seq = '{2'h2, 2'h3, 2'h1, 2'h0};
        for (int i = 0; i < 4 * n; i++) begin
            s = seq[i % 4];
            if (down) begin
                s = {s[0], s[1]};
            end
            hold(s[1], s[0], gap);
        end
    endtask : quad
endmodule : hspc_source
`default_nettype wire

//--- hspc_top_test.sv
// Self-checking testbench for the high speed pulse counter
`default_nettype none
module hspc_top_test
    import hspc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, rst_b, wr, rd, ext_rst, ext_start, power_restore;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, count_value;
    logic        in0, in1, contact, dirmon, irq;
    int          bad_count, compares;
    logic [7:0]  ofs [9];

    hspc_source src (.clk(clk), .phase_a(in0), .phase_b(in1));

    hspc_top uut (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .COUNT_INPUT_TERMINAL_0(in0), .COUNT_INPUT_TERMINAL_1(in1),
        .EXTERNAL_RESET_TERMINAL(ext_rst), .EXTERNAL_START_TERMINAL(ext_start),
        .POWER_RESTORE(power_restore), .COUNT_VALUE(count_value), .OUTPUT_CONTACT(contact),
        .DIRECTION_MONITOR_FLAG(dirmon), .IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge clk);
    endtask : rd_reg

    task automatic look(input logic [31:0] c, input logic k, input logic d);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(count_value, c);
        chk({30'h0, dirmon, contact}, {30'h0, d, k});
        @(posedge clk);
    endtask : look

    task automatic look_irq(input logic e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge clk);
    endtask : look_irq

    task automatic power_pulse();
        power_restore <= 1'b1;
        @(posedge clk);
        power_restore <= 1'b0;
    endtask : power_pulse

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    initial begin
        {rst_b, wr, rd, ext_rst, ext_start, power_restore} = 6'h00;
        addr = 8'h00;
        wdata = 32'h0;
        ofs = '{HSPC_CTRL_OFS, HSPC_CMD_OFS, HSPC_SETLO_OFS, HSPC_SETHI_OFS, HSPC_COUNT_OFS,
            HSPC_STATUS_OFS, HSPC_IRQ_STAT_OFS, HSPC_IRQ_MASK_OFS, 8'h20};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (ofs[i]) rd_reg(ofs[i], 32'h0);
        wr_reg(HSPC_COUNT_OFS, 32'h5);
        rd_reg(HSPC_COUNT_OFS, 32'h0);
        $display("test reset done");
        wr_reg(HSPC_SETLO_OFS, 32'h0000FFFB);
        wr_reg(HSPC_SETHI_OFS, 32'h0000FFFF);
        wr_reg(HSPC_CTRL_OFS, 32'h3);
        src.pulse(0, 6, 2);
        look(32'hFFFFFFFA, 1'b0, 1'b1);
        wr_reg(HSPC_CTRL_OFS, 32'h1);
        src.pulse(0, 1, 1);
        look(32'hFFFFFFFB, 1'b1, 1'b0);
        look_irq(1'b0);
        wr_reg(HSPC_IRQ_MASK_OFS, 32'h1);
        look_irq(1'b1);
        src.pulse(0, 2, 3);
        look(32'hFFFFFFFD, 1'b1, 1'b0);
        wr_reg(HSPC_CTRL_OFS, 32'h3);
        src.pulse(0, 3, 2);
        look(32'hFFFFFFFA, 1'b0, 1'b1);
        rd_reg(HSPC_IRQ_STAT_OFS, 32'h3);
        wr_reg(HSPC_IRQ_STAT_OFS, 32'h3);
        look_irq(1'b0);
        rd_reg(HSPC_COUNT_OFS, 32'hFFFFFFFA);
        wr_reg(HSPC_CTRL_OFS, 32'h0);
        src.pulse(0, 2, 2);
        look(32'hFFFFFFFA, 1'b0, 1'b0);
        wr_reg(HSPC_CMD_OFS, 32'h1);
        look(32'h0, 1'b0, 1'b0);
        $display("test single done");
        wr_reg(HSPC_SETLO_OFS, 32'h3);
        wr_reg(HSPC_SETHI_OFS, 32'h0);
        wr_reg(HSPC_CTRL_OFS, 32'h5);
        src.pulse(0, 3, 1);
        look(32'h3, 1'b1, 1'b0);
        src.pulse(1, 1, 2);
        look(32'h2, 1'b0, 1'b1);
        wr_reg(HSPC_CMD_OFS, 32'h1);
        wr_reg(HSPC_CTRL_OFS, 32'h19);
        src.quad(2, 0, 1);
        look(32'h8, 1'b1, 1'b0);
        src.quad(1, 1, 2);
        look(32'h4, 1'b1, 1'b1);
        wr_reg(HSPC_CMD_OFS, 32'h1);
        wr_reg(HSPC_CTRL_OFS, 32'h9);
        src.quad(3, 0, 2);
        look(32'h3, 1'b1, 1'b0);
        src.quad(1, 1, 3);
        look(32'h2, 1'b0, 1'b1);
        $display("test dual and quadrature done");
        wr_reg(HSPC_CTRL_OFS, 32'h21);
        wr_reg(HSPC_CMD_OFS, 32'h1);
        rd_reg(HSPC_STATUS_OFS, 32'h0);
        src.pulse(0, 2, 2);
        look(32'h0, 1'b0, 1'b0);
        ext_start <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(HSPC_STATUS_OFS, 32'h4);
        src.pulse(0, 2, 2);
        look(32'h2, 1'b0, 1'b0);
        ext_start <= 1'b0;
        wr_reg(HSPC_CTRL_OFS, 32'h41);
        src.pulse(0, 1, 2);
        look(32'h3, 1'b1, 1'b0);
        ext_rst <= 1'b1;
        look(32'h0, 1'b0, 1'b0);
        rd_reg(HSPC_IRQ_STAT_OFS, 32'hB);
        ext_rst <= 1'b0;
        $display("test start and external reset done");
        wr_reg(HSPC_CTRL_OFS, 32'h81);
        src.pulse(0, 3, 2);
        power_pulse();
        look(32'h3, 1'b1, 1'b0);
        wr_reg(HSPC_CTRL_OFS, 32'h1);
        power_pulse();
        look(32'h0, 1'b0, 1'b0);
        $display("test latched done");
        finish_test();
    end
endmodule : hspc_top_test
`default_nettype wire
